// ===== shared/csp_map.svh
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH
// register byte offsets
`define CSP_CTRL 5'h00
`define CSP_ADDR 5'h04
`define CSP_WDATA 5'h08
`define CSP_CYCLE 5'h0c
`define CSP_STATUS 5'h10
`define CSP_RDATA 5'h14
// control fields
`define CSP_CTRL_RESET 0
`define CSP_CTRL_STOP 1
`define CSP_CTRL_REL 2
`define CSP_CTRL_MASK 4
`define CSP_MASK_RST 3'h0
// cycle fields
`define CSP_CYC_RNW 3
`define CSP_CYC_LDS 4
`define CSP_CYC_UDS 5
`define CSP_CYC_IACK 6
// status fields
`define CSP_ST_BUSY 0
`define CSP_ST_DONE 1
`define CSP_ST_FAULT 2
`define CSP_ST_AUTOVEC 3
`define CSP_ST_RETRY 4
`define CSP_ST_WIDE 5
`define CSP_ST_HALTIN 6
`define CSP_ST_STOP 7
`define CSP_ST_LVL 8
`define CSP_ST_IRQ 11
`define CSP_ST_RSTOUT 12
// timing and codes
`define CSP_E_PERIOD 4'd10
`define CSP_E_LOW 4'd6
`define CSP_MODE_SETTLE 2'd2
`define CSP_SPACE_CPU 3'h7
`define CSP_LVL_NMI 3'h7
`define CSP_SYNC_RST 10'h3ff
`endif

// ===== shared/csp_pkg.sv
package csp_pkg;
  typedef enum logic [3:0] {
    CSP_IDLE, CSP_LAUNCH, CSP_SETUP, CSP_STROBE, CSP_WAIT,
    CSP_PSYNC, CSP_PVMA, CSP_TERM, CSP_RETRY, CSP_HALTED
  } csp_state_type;
endpackage

// ===== src/csp_system_control.sv
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "csp_map.svh"
module csp_system_control #(
  parameter int TWO_PIN = 0,
  parameter int RST_PULSE = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt request pins
  input wire logic irq_level_bit0_n,
  input wire logic irq_level_bit1_n,
  input wire logic irq_level_bit2_n,
  input wire logic irq_level_shared_pin_n,
  // system control pins
  input wire logic bus_fault_in_n,
  input wire logic reset_pin_in_n,
  output logic reset_pin_out_n,
  output logic reset_pin_oe,
  input wire logic halt_pin_in_n,
  output logic halt_pin_out_n,
  output logic halt_pin_oe,
  input wire logic width_sel_in,
  // peripheral control
  input wire logic periph_addr_valid_in_n,
  output logic mem_addr_valid_out_n,
  output logic mem_addr_valid_oe,
  output logic periph_enable,
  // space codes
  output logic space_code_bit0,
  output logic space_code_bit1,
  output logic space_code_bit2,
  output logic space_code_oe,
  // address and data
  output logic [23:0] addr_out,
  output logic addr_oe,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // bus control
  output logic addr_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic rnw,
  output logic ctl_oe,
  input wire logic transfer_ack_in_n
);
  import csp_pkg::*;

  if (RST_PULSE < 1 || RST_PULSE > 65535) begin : g_chk
    $error("RST_PULSE out of range");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // synchronizers; the first stage feeds only the second
  logic [9:0] s1_reg;
  logic [9:0] s2_reg;
  logic [15:0] d1_reg;
  logic [15:0] d2_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_reg <= `CSP_SYNC_RST;
      s2_reg <= `CSP_SYNC_RST;
      d1_reg <= 16'h0000;
      d2_reg <= 16'h0000;
    end else begin
      s1_reg <= {width_sel_in, transfer_ack_in_n, periph_addr_valid_in_n,
                 halt_pin_in_n, reset_pin_in_n, bus_fault_in_n,
                 irq_level_shared_pin_n, irq_level_bit2_n,
                 irq_level_bit1_n, irq_level_bit0_n};
      s2_reg <= s1_reg;
      d1_reg <= data_in;
      d2_reg <= d1_reg;
    end
  end

  logic fault_s, rst_s, halt_s, vpa_s, ack_s, width_s;
  assign fault_s = !s2_reg[4];
  assign rst_s = !s2_reg[5];
  assign halt_s = !s2_reg[6];
  assign vpa_s = !s2_reg[7];
  assign ack_s = !s2_reg[8];
  assign width_s = s2_reg[9];

  // control state
  logic stop_reg, release_reg;
  logic [2:0] mask_reg;
  logic [15:0] rst_cnt_reg;
  logic [1:0] rst_own_reg;
  logic ext_init, rst_i, halt_ext;
  // own reset drive echoes back through the synchronizer, so it is masked
  assign ext_init = rst_s && halt_s && !reset_pin_oe && (rst_own_reg == 2'b00);
  assign rst_i = !nrst || ext_init;
  assign halt_ext = halt_s && !stop_reg;

  // interrupt level decode
  logic [2:0] lvl_raw, lvl_prev_reg, lvl_reg;
  logic irq_reg;
  always_comb begin
    lvl_raw[1] = !s2_reg[1];
    if (TWO_PIN != 0) begin
      lvl_raw[0] = !s2_reg[3];
      lvl_raw[2] = !s2_reg[3];
    end else begin
      lvl_raw[0] = !s2_reg[0];
      lvl_raw[2] = !s2_reg[2];
    end
  end
  always_ff @(posedge clk) begin
    if (rst_i) begin
      lvl_prev_reg <= 3'h0;
      lvl_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      lvl_prev_reg <= lvl_raw;
      if (lvl_raw == lvl_prev_reg) begin
        lvl_reg <= lvl_raw;
      end
      irq_reg <= (lvl_reg == `CSP_LVL_NMI) || (lvl_reg > mask_reg);
    end
  end

  // width mode captured shortly after reset release
  logic [1:0] mcnt_reg;
  logic wide_reg;
  always_ff @(posedge clk) begin
    if (rst_i) begin
      mcnt_reg <= 2'd0;
      wide_reg <= 1'b1;
    end else if (mcnt_reg != 2'd3) begin
      mcnt_reg <= mcnt_reg + 2'd1;
      // synchronizer shows reset values until the second edge after release
      if (mcnt_reg == `CSP_MODE_SETTLE) begin
        wide_reg <= width_s;
      end
    end
  end

  // enable clock ring; only nrst touches it so it never stops for bus state
  logic [3:0] e_cnt_reg;
  logic [3:0] e_next;
  assign e_next = (e_cnt_reg == `CSP_E_PERIOD - 4'd1) ? 4'd0 : e_cnt_reg + 4'd1;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      e_cnt_reg <= 4'd0;
      periph_enable <= 1'b0;
    end else begin
      e_cnt_reg <= e_next;
      periph_enable <= (e_next >= `CSP_E_LOW);
    end
  end

  // software reset pulse and open-drain pin levels
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_own_reg <= 2'b00;
      reset_pin_out_n <= 1'b0;
      halt_pin_out_n <= 1'b0;
      reset_pin_oe <= 1'b0;
      halt_pin_oe <= 1'b0;
    end else begin
      rst_own_reg <= {rst_own_reg[0], reset_pin_oe};
      reset_pin_out_n <= 1'b0;
      halt_pin_out_n <= 1'b0;
      reset_pin_oe <= (rst_cnt_reg != 16'd0);
      halt_pin_oe <= stop_reg;
    end
  end

  // bus cycle state
  csp_state_type state_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg, rdata_reg;
  logic [6:0] cyc_reg;
  logic start;
  logic done_set, fault_set, av_set, retry_set;
  logic done_reg, fault_reg, av_reg, retry_reg;
  logic bus_req, bus_take;
  assign bus_req = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;
  assign start = bus_take && avs_write && (avs_address == `CSP_CYCLE)
                 && (state_reg == CSP_IDLE) && !release_reg && !halt_ext;

  always_ff @(posedge clk) begin
    if (rst_i) begin
      state_reg <= CSP_IDLE;
      cyc_reg <= 7'h00;
      addr_out <= 24'h000000;
      data_out <= 16'h0000;
      rdata_reg <= 16'h0000;
      {space_code_bit2, space_code_bit1, space_code_bit0} <= 3'h0;
      addr_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      mem_addr_valid_out_n <= 1'b1;
      rnw <= 1'b1;
      {addr_oe, data_oe, ctl_oe, space_code_oe, mem_addr_valid_oe} <= 5'b00000;
      {done_set, fault_set, av_set, retry_set} <= 4'b0000;
    end else begin
      {done_set, fault_set, av_set, retry_set} <= 4'b0000;
      case (state_reg)
        CSP_IDLE: begin
          addr_oe <= 1'b0;
          data_oe <= 1'b0;
          rnw <= 1'b1;
          // release floats controls too; halt leaves them driven negated
          ctl_oe <= !release_reg;
          space_code_oe <= !release_reg;
          mem_addr_valid_oe <= !release_reg;
          if (halt_ext && !release_reg) begin
            state_reg <= CSP_HALTED;
          end else if (start) begin
            cyc_reg <= avs_writedata[6:0];
            state_reg <= CSP_LAUNCH;
          end
        end
        CSP_LAUNCH: begin
          // address, space and direction lead the strobe by a cycle
          if (cyc_reg[`CSP_CYC_IACK]) begin
            {space_code_bit2, space_code_bit1, space_code_bit0} <= `CSP_SPACE_CPU;
            addr_out <= {20'hfffff, lvl_reg, 1'b1};
          end else begin
            {space_code_bit2, space_code_bit1, space_code_bit0} <= cyc_reg[2:0];
            addr_out <= {addr_reg[23:1], wide_reg ? 1'b1 : addr_reg[0]};
          end
          rnw <= cyc_reg[`CSP_CYC_RNW] || cyc_reg[`CSP_CYC_IACK];
          addr_oe <= 1'b1;
          ctl_oe <= 1'b1;
          space_code_oe <= 1'b1;
          state_reg <= CSP_SETUP;
        end
        CSP_SETUP: begin
          addr_strobe_n <= 1'b0;
          data_out <= wide_reg ? wdata_reg : {8'h00, wdata_reg[7:0]};
          data_oe <= !rnw;
          if (rnw) begin
            lower_byte_strobe_n <= !cyc_reg[`CSP_CYC_LDS];
            upper_byte_strobe_n <= !(cyc_reg[`CSP_CYC_UDS] && wide_reg);
          end
          state_reg <= CSP_STROBE;
        end
        CSP_STROBE: begin
          lower_byte_strobe_n <= !cyc_reg[`CSP_CYC_LDS];
          upper_byte_strobe_n <= !(cyc_reg[`CSP_CYC_UDS] && wide_reg);
          state_reg <= CSP_WAIT;
        end
        CSP_WAIT: begin
          if (fault_s || ack_s || (vpa_s && cyc_reg[`CSP_CYC_IACK])) begin
            addr_strobe_n <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
          end
          if (fault_s && halt_s) begin
            retry_set <= 1'b1;
            state_reg <= CSP_RETRY;
          end else if (fault_s) begin
            fault_set <= 1'b1;
            state_reg <= CSP_TERM;
          end else if (ack_s) begin
            rdata_reg <= d2_reg;
            state_reg <= CSP_TERM;
          end else if (vpa_s && cyc_reg[`CSP_CYC_IACK]) begin
            av_set <= 1'b1;
            state_reg <= CSP_TERM;
          end else if (vpa_s) begin
            state_reg <= CSP_PSYNC;
          end
        end
        CSP_PSYNC: begin
          if (e_cnt_reg == `CSP_E_PERIOD - 4'd1) begin
            mem_addr_valid_out_n <= 1'b0;
            state_reg <= CSP_PVMA;
          end
        end
        CSP_PVMA: begin
          if (e_cnt_reg == `CSP_E_PERIOD - 4'd1) begin
            rdata_reg <= d2_reg;
            mem_addr_valid_out_n <= 1'b1;
            addr_strobe_n <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            state_reg <= CSP_TERM;
          end
        end
        CSP_TERM: begin
          // buses float a cycle after the strobes drop
          addr_oe <= 1'b0;
          data_oe <= 1'b0;
          rnw <= 1'b1;
          done_set <= 1'b1;
          state_reg <= CSP_IDLE;
        end
        CSP_RETRY: begin
          addr_oe <= 1'b0;
          data_oe <= 1'b0;
          rnw <= 1'b1;
          if (!halt_s) begin
            state_reg <= CSP_LAUNCH;
          end
        end
        CSP_HALTED: begin
          addr_oe <= 1'b0;
          data_oe <= 1'b0;
          if (!halt_ext) begin
            state_reg <= CSP_IDLE;
          end
        end
        default: begin
          state_reg <= CSP_IDLE;
        end
      endcase
    end
  end

  // register file; a completed write takes effect at the accepting edge
  logic [31:0] status_word;
  logic wr_ctrl, wr_status;
  assign wr_ctrl = bus_take && avs_write && (avs_address == `CSP_CTRL);
  assign wr_status = bus_take && avs_write && (avs_address == `CSP_STATUS);
  always_ff @(posedge clk) begin
    if (rst_i) begin
      stop_reg <= 1'b0;
      release_reg <= 1'b0;
      mask_reg <= `CSP_MASK_RST;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
    end else begin
      if (wr_ctrl && avs_byteenable[0]) begin
        stop_reg <= avs_writedata[`CSP_CTRL_STOP];
        release_reg <= avs_writedata[`CSP_CTRL_REL];
        mask_reg <= avs_writedata[`CSP_CTRL_MASK +: 3];
      end
      if (bus_take && avs_write && avs_address == `CSP_ADDR) begin
        addr_reg <= 24'(be_merge({8'h00, addr_reg}, avs_writedata, avs_byteenable));
      end
      if (bus_take && avs_write && avs_address == `CSP_WDATA) begin
        wdata_reg <= 16'(be_merge({16'h0000, wdata_reg}, avs_writedata, avs_byteenable));
      end
    end
  end

  // reset pulse counter survives its own pulse, so nrst alone clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rst_cnt_reg <= 16'd0;
    end else if (wr_ctrl && avs_byteenable[0] && avs_writedata[`CSP_CTRL_RESET]
                 && rst_cnt_reg == 16'd0) begin
      rst_cnt_reg <= 16'(RST_PULSE);
    end else if (rst_cnt_reg != 16'd0) begin
      rst_cnt_reg <= rst_cnt_reg - 16'd1;
    end
  end

  // sticky completion flags: write one clears, a new event wins
  always_ff @(posedge clk) begin
    if (rst_i) begin
      {done_reg, fault_reg, av_reg, retry_reg} <= 4'b0000;
    end else begin
      done_reg <= done_set ||
                  (done_reg && !(wr_status && avs_writedata[`CSP_ST_DONE]));
      fault_reg <= fault_set ||
                   (fault_reg && !(wr_status && avs_writedata[`CSP_ST_FAULT]));
      av_reg <= av_set ||
                (av_reg && !(wr_status && avs_writedata[`CSP_ST_AUTOVEC]));
      retry_reg <= retry_set ||
                   (retry_reg && !(wr_status && avs_writedata[`CSP_ST_RETRY]));
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[`CSP_ST_BUSY] = (state_reg != CSP_IDLE) && (state_reg != CSP_HALTED);
    status_word[`CSP_ST_DONE] = done_reg;
    status_word[`CSP_ST_FAULT] = fault_reg;
    status_word[`CSP_ST_AUTOVEC] = av_reg;
    status_word[`CSP_ST_RETRY] = retry_reg;
    status_word[`CSP_ST_WIDE] = wide_reg;
    status_word[`CSP_ST_HALTIN] = (state_reg == CSP_HALTED);
    status_word[`CSP_ST_STOP] = stop_reg;
    status_word[`CSP_ST_LVL +: 3] = lvl_reg;
    status_word[`CSP_ST_IRQ] = irq_reg;
    status_word[`CSP_ST_RSTOUT] = reset_pin_oe;
  end

  // slave answers one cycle after the request; waitrequest idles high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `CSP_CTRL: avs_readdata <= {25'h0, mask_reg, 1'b0, release_reg, stop_reg,
                                    reset_pin_oe};
        `CSP_ADDR: avs_readdata <= {8'h00, addr_reg};
        `CSP_WDATA: avs_readdata <= {16'h0000, wdata_reg};
        `CSP_CYCLE: avs_readdata <= {25'h0, cyc_reg};
        `CSP_STATUS: avs_readdata <= status_word;
        `CSP_RDATA: avs_readdata <= {16'h0000, rdata_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
endmodule

// ===== tb/csp_system_control_asserts.sv
`timescale 1ns/1ps
module csp_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins watched
  input wire logic periph_enable,
  input wire logic periph_addr_valid_in_n,
  input wire logic mem_addr_valid_out_n,
  input wire logic mem_addr_valid_oe,
  input wire logic addr_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic ctl_oe,
  input wire logic width_sel_in,
  input wire logic [23:0] addr_out,
  input wire logic addr_oe,
  input wire logic data_oe,
  input wire logic space_code_bit0,
  input wire logic space_code_bit1,
  input wire logic space_code_bit2,
  input wire logic space_code_oe,
  input wire logic halt_pin_in_n,
  input wire logic halt_pin_oe,
  input wire logic reset_pin_out_n,
  input wire logic halt_pin_out_n
);
  logic [2:0] sc;
  assign sc = {space_code_bit2, space_code_bit1, space_code_bit0};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_enable_shape: assert property ($rose(periph_enable) |->
    periph_enable[*4] ##1 !periph_enable[*6] ##1 periph_enable)
    else $error("enable clock shape wrong");
  chk_vma_cause: assert property (mem_addr_valid_oe && !mem_addr_valid_out_n |->
    $past(periph_addr_valid_in_n, 2) == 1'b0)
    else $error("memory valid without peripheral valid");
  chk_vma_in_cycle: assert property (mem_addr_valid_oe && !mem_addr_valid_out_n |->
    ctl_oe && !addr_strobe_n)
    else $error("memory valid outside a strobed cycle");
  chk_narrow_upper: assert property (!width_sel_in && ctl_oe |-> upper_byte_strobe_n)
    else $error("upper strobe asserted in narrow mode");
  chk_iack_addr: assert property (addr_oe && space_code_oe && sc == 3'h7 |->
    addr_out[23:4] == 20'hfffff && addr_out[0])
    else $error("acknowledge address lines not high");
  chk_space_stable: assert property (ctl_oe && !addr_strobe_n |->
    space_code_oe && $stable(sc))
    else $error("space code moved under address strobe");
  chk_halt_float: assert property ((!halt_pin_oe && !halt_pin_in_n)[*8] |->
    !addr_oe && !data_oe && addr_strobe_n)
    else $error("bus not floated in halt");
  chk_open_drain: assert property (!reset_pin_out_n && !halt_pin_out_n)
    else $error("open drain pin drives high");
  cov_vma: cover property (mem_addr_valid_oe && !mem_addr_valid_out_n);
  cov_iack: cover property (addr_oe && sc == 3'h7);
  cov_halt: cover property ((!halt_pin_in_n)[*8]);
endmodule
bind csp_system_control csp_chk i_csp_chk (
  .clk, .nrst, .periph_enable, .periph_addr_valid_in_n, .mem_addr_valid_out_n,
  .mem_addr_valid_oe, .addr_strobe_n, .upper_byte_strobe_n, .ctl_oe, .width_sel_in,
  .addr_out, .addr_oe, .data_oe, .space_code_bit0, .space_code_bit1, .space_code_bit2,
  .space_code_oe, .halt_pin_in_n, .halt_pin_oe, .reset_pin_out_n, .halt_pin_out_n);

// ===== tb/csp_far_end.sv
`timescale 1ns/1ps
module csp_far_end (
  // control from the bench
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  // device bus
  input wire logic ctl_oe,
  input wire logic addr_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic rnw,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  input wire logic space_code_bit0,
  input wire logic space_code_bit1,
  input wire logic space_code_bit2,
  // answers
  output logic transfer_ack_in_n,
  output logic bus_fault_in_n,
  output logic periph_addr_valid_in_n,
  output logic halt_req,
  output logic [15:0] data_in,
  // what was seen
  output logic [23:0] seen_addr,
  output logic [15:0] seen_data,
  output logic [2:0] seen_space
);
  // mode 0 acknowledge, 1 fault, 2 fault with halt then retry, 3 peripheral
  logic strb, tried;
  logic [3:0] wt;
  logic [2:0] hold;
  assign strb = ctl_oe && !addr_strobe_n && !(lower_byte_strobe_n && upper_byte_strobe_n);
  initial begin
    {transfer_ack_in_n, bus_fault_in_n, periph_addr_valid_in_n, halt_req, tried} = 5'h1c;
    {data_in, wt, hold} = 23'h0;
  end
  always @(posedge clk) begin
    tried <= mode == 2'h2 && (tried || (halt_req && !strb));
    if (!strb) begin
      {transfer_ack_in_n, bus_fault_in_n, periph_addr_valid_in_n} <= 3'h7;
      // undriven lines keep changing so no stale value can pass for data
      data_in <= ~data_in;
      wt <= 4'h0;
      if (hold != 3'h0) hold <= hold - 3'h1;
      else halt_req <= 1'b0;
    end else begin
      wt <= wt + {3'h0, wt != 4'hf};
      seen_addr <= addr_out;
      seen_space <= {space_code_bit2, space_code_bit1, space_code_bit0};
      if (!rnw && data_oe) seen_data <= data_out;
      if (wt < dly || !rnw) data_in <= ~data_in;
      else data_in <= addr_out[16:1];
      if (wt >= dly) begin
        case (mode)
          2'h0: transfer_ack_in_n <= 1'b0;
          2'h1: bus_fault_in_n <= 1'b0;
          2'h2: begin
            if (tried) transfer_ack_in_n <= 1'b0;
            else {bus_fault_in_n, halt_req, hold} <= 5'h0c;
          end
          default: periph_addr_valid_in_n <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "csp_map.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst, avs_read, avs_write, avs_waitrequest, width_sel_in, tb_rst, tb_halt, halt_req;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, st, q;
  logic [3:0] avs_byteenable, far_dly;
  logic irq_level_bit0_n, irq_level_bit1_n, irq_level_bit2_n;
  logic bus_fault_in_n, transfer_ack_in_n, periph_addr_valid_in_n, reset_pin_in_n;
  logic halt_pin_in_n, reset_pin_out_n, reset_pin_oe, halt_pin_out_n, halt_pin_oe;
  logic mem_addr_valid_out_n, mem_addr_valid_oe, periph_enable, addr_oe, data_oe, rnw;
  logic space_code_bit0, space_code_bit1, space_code_bit2, space_code_oe, ctl_oe;
  logic addr_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n;
  logic [23:0] addr_out, seen_addr;
  logic [15:0] data_in, data_out, seen_data;
  logic [2:0] seen_space;
  logic [1:0] far_mode;
  int error_cnt = 0;
  int compares = 0;
  // {cycle word, far mode, expected {retried, autovector, fault}, answer delay}
  logic [15:0] rows [8] = '{16'h3d00, 16'h1106, 16'h2a48, 16'h3ea0,
                            16'h3dc1, 16'h3602, 16'h5fd0, 16'h5f03};
  assign reset_pin_in_n = !(reset_pin_oe || tb_rst);
  assign halt_pin_in_n = !(halt_pin_oe || tb_halt || halt_req);
  always #2 clk = ~clk;
  csp_system_control #(.TWO_PIN(0), .RST_PULSE(4)) i_csp_system_control (
    .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq_level_bit0_n, .irq_level_bit1_n,
    .irq_level_bit2_n, .irq_level_shared_pin_n(1'b1), .bus_fault_in_n, .reset_pin_in_n,
    .reset_pin_out_n, .reset_pin_oe, .halt_pin_in_n, .halt_pin_out_n, .halt_pin_oe,
    .width_sel_in, .periph_addr_valid_in_n, .mem_addr_valid_out_n, .mem_addr_valid_oe,
    .periph_enable, .space_code_bit0, .space_code_bit1, .space_code_bit2, .space_code_oe,
    .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .addr_strobe_n,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .rnw, .ctl_oe, .transfer_ack_in_n);
  csp_far_end i_csp_far_end (.clk, .mode(far_mode), .dly(far_dly), .ctl_oe, .addr_strobe_n,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .rnw, .addr_out, .data_out, .data_oe,
    .space_code_bit0, .space_code_bit1, .space_code_bit2, .transfer_ack_in_n,
    .bus_fault_in_n, .periph_addr_valid_in_n, .halt_req, .data_in, .seen_addr,
    .seen_data, .seen_space);
  task automatic results();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !wr, wr};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    r = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    if (n >= 64) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic run(input logic [15:0] row);
    int n;
    n = 0;
    {far_mode, far_dly} <= {row[7:6], 1'b0, row[2:0]};
    bus(1'b1, `CSP_STATUS, 32'h1e, q);
    bus(1'b1, `CSP_CYCLE, {25'h0, row[14:8]}, q);
    do begin
      bus(1'b0, `CSP_STATUS, 32'h0, st);
      n++;
    end while (st[`CSP_ST_DONE] !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      results();
    end
  endtask
  initial begin
    {nrst, avs_read, avs_write, tb_rst, tb_halt, far_mode, far_dly} = 11'h0;
    {avs_address, avs_writedata, avs_byteenable, width_sel_in} = 42'h1f;
    {irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n} = 3'h7;
    repeat (6) @(posedge clk);
    check({avs_waitrequest, addr_oe, data_oe, ctl_oe, periph_enable}, 5'h10);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_WIDE], 1'b1);
    for (int m = 3; m <= 7; m += 4) begin
      bus(1'b1, `CSP_CTRL, 32'(m << 4), q);
      for (int l = 0; l < 8; l++) begin
        {irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n} <= ~l[2:0];
        repeat (8) @(posedge clk);
        bus(1'b0, `CSP_STATUS, 32'h0, st);
        check(st[10:8], l[2:0]);
        check(st[`CSP_ST_IRQ], l == 7 || l > m);
      end
    end
    // one-sample glitch to level 2 must not be taken; level 5 that follows it must be read back
    {irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n} <= 3'h5;
    @(posedge clk);
    {irq_level_bit2_n, irq_level_bit1_n, irq_level_bit0_n} <= 3'h2;
    repeat (8) @(posedge clk);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[10:8], 3'h5);
    bus(1'b1, `CSP_ADDR, 32'h012344, q);
    bus(1'b1, `CSP_WDATA, 32'hbeef, q);
    foreach (rows[i]) begin
      run(rows[i]);
      check(st[4:2], rows[i][5:3]);
      check(seen_space, rows[i][10:8]);
      check(seen_addr, rows[i][14] ? 24'hfffffb : 24'h012345);
      bus(1'b0, `CSP_RDATA, 32'h0, q);
      if (!rows[i][11]) check(seen_data, 16'hbeef);
      else if (rows[i][15:13] == 3'h1 && rows[i][7:6] != 2'h1) check(q, 32'h91a2);
    end
    bus(1'b1, 5'h1c, 32'hffff, q);
    bus(1'b0, 5'h18, 32'h0, q);
    check(q, 32'h0);
    avs_byteenable <= 4'h1;
    bus(1'b1, `CSP_ADDR, 32'hffffff, q);
    avs_byteenable <= 4'hf;
    bus(1'b1, `CSP_CTRL, 32'h71, q);
    repeat (3) @(posedge clk);
    check(reset_pin_oe, 1'b1);
    repeat (8) @(posedge clk);
    check(reset_pin_oe, 1'b0);
    bus(1'b0, `CSP_ADDR, 32'h0, q);
    check(q, 32'h0123ff);
    bus(1'b1, `CSP_CTRL, 32'h04, q);
    repeat (2) @(posedge clk);
    check({ctl_oe, space_code_oe, mem_addr_valid_oe, addr_oe}, 4'h0);
    bus(1'b1, `CSP_CYCLE, 32'h3d, q);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_BUSY], 1'b0);
    bus(1'b1, `CSP_CTRL, 32'h72, q);
    repeat (2) @(posedge clk);
    check(halt_pin_oe, 1'b1);
    bus(1'b1, `CSP_CTRL, 32'h70, q);
    tb_halt <= 1'b1;
    repeat (12) @(posedge clk);
    check({addr_oe, data_oe, addr_strobe_n, ctl_oe}, 4'h3);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_HALTIN], 1'b1);
    {tb_halt, tb_rst} <= 2'b01;
    repeat (8) @(posedge clk);
    tb_rst <= 1'b0;
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_DONE], 1'b1);
    {tb_halt, tb_rst} <= 2'b11;
    repeat (8) @(posedge clk);
    {tb_halt, tb_rst} <= 2'b00;
    repeat (6) @(posedge clk);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_DONE], 1'b0);
    {nrst, width_sel_in} <= 2'b00;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `CSP_STATUS, 32'h0, st);
    check(st[`CSP_ST_WIDE], 1'b0);
    bus(1'b1, `CSP_ADDR, 32'h000101, q);
    run(16'h3d00);
    check(seen_addr, 24'h000101);
    bus(1'b0, `CSP_RDATA, 32'h0, q);
    check(q[7:0], 8'h80);
    results();
  end
endmodule
